// [hdl/pinmux_pkg.sv]
// Purpose: Shared constants and types for the port alternate-function multiplexer.
// Assumes: AHB-Lite register window decoded on byte address bits [7:0].
// Notes: Each offset, field position and reset value is named once here.
package pinmux_pkg;

	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] OFS_IO_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFS_IO_CONTROL_THREE = 8'h04;
	localparam logic [7:0] OFS_PORT1_DATA = 8'h08;
	localparam logic [7:0] OFS_PORT2_DATA = 8'h0C;
	localparam logic [7:0] OFS_PORT0_ALT = 8'h10;
	localparam logic [7:0] OFS_PORT1_ALT = 8'h14;
	localparam logic [7:0] OFS_PORT2_ALT = 8'h18;
	localparam logic [7:0] OFS_CHIP_CONFIG = 8'h1C;
	localparam logic [7:0] OFS_FAST_SHARE = 8'h20;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFS_PIN_LEVELS = 8'h2C;
	localparam logic [7:0] OFS_CAPTURE = 8'h30;

	// Field positions.
	localparam int IO_CONTROL_ONE_EXT_SRC_BIT = 1;
	localparam int IO_CONTROL_THREE_PULSE_WIDTH_OUT_ONE_BIT = 2;
	localparam int IO_CONTROL_THREE_PULSE_WIDTH_OUT_TWO_BIT = 3;
	localparam int CCB_DYN_WIDTH_BIT = 1;
	localparam int ST_INT7_BIT = 0;
	localparam int ST_CAP_BIT = 1;

	// Pin masks of the alternate functions.
	localparam logic [7:0] P0_CHECK_MASK = 8'h4F;
	localparam logic [7:0] P1_ALT_MASK = 8'hE0;
	localparam logic [7:0] P2_OUT_ALT_MASK = 8'h21;

	// Reset values.
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_PORT_DATA = 8'hFF;
	localparam logic [7:0] RST_CHIP_CONFIG = 8'h00;
	localparam logic [15:0] RST_CAPTURE = 16'h0000;

	// Phase of the external bus cycle as given by the bus controller.
	typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} bus_phase_t;

endpackage

// [hdl/capture_if.sv]
// Purpose: Carries the timer capture pin, timer value and capture results.
// Assumes: One clock domain.
// Notes: The mux drives pin and value; the capture unit answers.
`timescale 1ns/10ps
`default_nettype none
interface capture_if;
	logic pin;
	logic [15:0] timer_value;
	logic capture_pulse;
	logic [15:0] capture_value;
	modport unit (input pin, input timer_value, output capture_pulse, output capture_value);
	modport host (output pin, output timer_value, input capture_pulse, input capture_value);
endinterface
`default_nettype wire

// [hdl/timer_b_capture_unit.sv]
// Purpose: Rising-edge capture of the timer value on the capture pin.
// Assumes: Pin is synchronous to the clock.
// Notes: The pulse lasts one cycle, together with the new captured value.
`timescale 1ns/10ps
`default_nettype none
module timer_b_capture_unit import pinmux_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Capture signals.
	capture_if.unit cap
);
	logic prev_reg;
	logic pulse_reg;
	logic [15:0] value_reg;

	assign cap.capture_pulse = pulse_reg;
	assign cap.capture_value = value_reg;

	// Detects the rising edge and copies the timer value.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			prev_reg <= 1'b1; // A pin resting on its pull-up gives no false capture.
			pulse_reg <= 1'b0;
			value_reg <= RST_CAPTURE;
		end else begin
			prev_reg <= cap.pin;
			pulse_reg <= cap.pin & ~prev_reg;
			if (cap.pin && !prev_reg) begin
				value_reg <= cap.timer_value;
			end
		end
	end

	a_capture_copy_value: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		pulse_reg |-> value_reg == $past(cap.timer_value) && !$past(prev_reg))
		else $error("Capture value does not match the timer at the edge.");

endmodule // timer_b_capture_unit
`default_nettype wire

// [hdl/port_alternate_function_mux.sv]
// Purpose: Pin sharing between plain ports and alternate peripheral functions.
// Assumes: AHB-Lite slave with zero wait states; pins synchronous to the clock.
// Notes: Every pin output is registered, so pins follow their cause by one cycle.
// Overview of operation
// - Port zero defaults to input only.
// - Check bits use port-zero pins 0-3 and 6.
// - Port one quasi, push-pull when alternate, except input pin 7.
// - Control three bit two: pulse one on pin 3.
// - Control three bit three: pulse two on pin 4.
// - Control one bit one picks interrupt source.
// - Bus request driven while cycle pending.
// - Hold acknowledge shows bus released.
// - Port two carries transmit, receive, pulse zero.
// - Pin 3 clocks timer and baud; 4 resets.
// - Pin 6 high counts down, low up.
// - Pin 7 rising edge captures, raises interrupt.
// - Low address/data: address, then bidirectional data.
// - Narrow bus: upper pins drive address only.
// - Six fast outputs; 4,5 share inputs 2,3.
// - Four fast inputs; 0,1 feed timer.
// - Config bit one low locks narrow bus.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module port_alternate_function_mux import pinmux_pkg::*; #(
	parameter int PORT_W = 8
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output logic irq_o,
	// Port pins.
	input wire logic [PORT_W-1:0] port0_in_i,
	output logic [PORT_W-1:0] port0_out_o,
	output logic [PORT_W-1:0] port0_oe_o,
	input wire logic [PORT_W-1:0] port1_in_i,
	output logic [PORT_W-1:0] port1_out_o,
	output logic [PORT_W-1:0] port1_oe_o,
	input wire logic [PORT_W-1:0] port2_in_i,
	output logic [PORT_W-1:0] port2_out_o,
	output logic [PORT_W-1:0] port2_oe_o,
	// Peripheral sources.
	input wire logic [4:0] memory_check_bits_out_i,
	input wire logic [4:0] memory_check_bits_oe_i,
	input wire logic pulse_width_out_zero_i,
	input wire logic pulse_width_out_one_i,
	input wire logic pulse_width_out_two_i,
	input wire logic serial_txd_i,
	input wire logic cycle_pending_i,
	input wire logic bus_released_i,
	input wire logic [15:0] timer_b_value_i,
	// Peripheral destinations.
	output logic [4:0] memory_check_bits_in_o,
	output logic interrupt_seven_o,
	output logic timer_b_capture_interrupt_o,
	output logic hold_request_o,
	output logic serial_rxd_o,
	output logic timer_b_clock_input_o,
	output logic baud_clock_input_o,
	output logic timer_b_reset_input_o,
	output logic timer_b_direction_input_o,
	output logic timer_b_alt_clock_o,
	output logic timer_b_alt_reset_o,
	// External address/data bus.
	input wire bus_phase_t bus_phase_i,
	input wire logic bus_write_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic [15:0] bus_wdata_i,
	input wire logic width_select_pin_i,
	input wire logic [7:0] low_addr_data_pins_in_i,
	input wire logic [7:0] high_addr_data_pins_in_i,
	output logic [7:0] low_addr_data_pins_out_o,
	output logic [7:0] low_addr_data_pins_oe_o,
	output logic [7:0] high_addr_data_pins_out_o,
	output logic [7:0] high_addr_data_pins_oe_o,
	output logic [15:0] bus_rdata_o,
	output logic bus_is_16_o,
	// Fast input and output pins.
	input wire logic [5:0] fast_output_pins_i,
	input wire logic [1:0] fast_in_dedicated_i,
	input wire logic [1:0] fast_shared_in_i,
	output logic [3:0] fast_out_dedicated_o,
	output logic [1:0] fast_shared_out_o,
	output logic [1:0] fast_shared_oe_o,
	output logic [3:0] fast_input_pins_o
);
	logic [7:0] io_control_one_reg, io_control_three_reg, port1_data_reg, port2_data_reg;
	logic [7:0] port1_alt_reg, port2_alt_reg, chip_config_byte_reg, wr_addr_reg;
	logic port0_alt_reg, ext_prev_reg, wr_pend_reg, ext_src, bus16, addr_phase;
	logic [1:0] fast_share_reg, status_reg, mask_reg, status_set, status_clr;
	logic [31:0] rdata_next;
	logic [7:0] p1_sel, p1_val, p1_drv, p1_out_next, p1_oe_next;
	logic [7:0] p2_sel, p2_val, p2_drv, p2_out_next, p2_oe_next;
	logic [7:0] lo_out_next, lo_oe_next, hi_out_next, hi_oe_next;
	capture_if cap ();

	// Timer capture runs in its own small unit.
	assign cap.pin = port2_in_i[7];
	assign cap.timer_value = timer_b_value_i;
	timer_b_capture_unit timer_b_capture_unit_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.cap(cap));

	// Alternate selections, values and drive kinds per port-one and port-two pin.
	assign p1_sel = {port1_alt_reg[7:5], io_control_three_reg[IO_CONTROL_THREE_PULSE_WIDTH_OUT_TWO_BIT],
		io_control_three_reg[IO_CONTROL_THREE_PULSE_WIDTH_OUT_ONE_BIT], 3'h0};
	assign p1_val = {1'b0, bus_released_i, cycle_pending_i, pulse_width_out_two_i,
		pulse_width_out_one_i, 3'h0};
	assign p1_drv = 8'h78; // Pin 7 is the hold request input, so it does not drive when alternate.
	assign p2_sel = port2_alt_reg & P2_OUT_ALT_MASK;
	assign p2_val = {2'h0, pulse_width_out_zero_i, 4'h0, serial_txd_i};
	assign p2_drv = P2_OUT_ALT_MASK;

	// One mux cell per pin: push-pull alternate except port-one pin 7, which does not drive, else quasi from the data register.
	for (genvar i = 0; i < 8; i++) begin : g_pin
		assign p1_out_next[i] = p1_sel[i] ? p1_val[i] : port1_data_reg[i];
		assign p1_oe_next[i] = p1_sel[i] ? p1_drv[i] : ~port1_data_reg[i];
		assign p2_out_next[i] = p2_sel[i] ? p2_val[i] : port2_data_reg[i];
		assign p2_oe_next[i] = p2_sel[i] ? p2_drv[i] : ~port2_data_reg[i];
	end

	// Interrupt source and bus width selection.
	assign ext_src = io_control_one_reg[IO_CONTROL_ONE_EXT_SRC_BIT] ? port0_in_i[7] : port2_in_i[2];
	assign bus16 = chip_config_byte_reg[CCB_DYN_WIDTH_BIT] & width_select_pin_i;

	// Address/data pin drive per bus phase.
	always_comb begin
		lo_out_next = 8'h00;
		lo_oe_next = 8'h00;
		hi_out_next = bus_addr_i[15:8];
		hi_oe_next = bus16 ? 8'h00 : 8'hFF;
		unique case (bus_phase_i)
			PH_IDLE: lo_out_next = 8'h00;
			PH_ADDR: begin
				lo_out_next = bus_addr_i[7:0];
				lo_oe_next = 8'hFF;
				hi_oe_next = 8'hFF;
			end
			PH_DATA: begin
				lo_out_next = bus_wdata_i[7:0];
				lo_oe_next = {8{bus_write_i}};
				if (bus16) begin
					hi_out_next = bus_wdata_i[15:8];
					hi_oe_next = {8{bus_write_i}};
				end
			end
		endcase
	end

	// Registers the port and address/data pin outputs and the bus width flag.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			port0_out_o <= 8'h00;
			port0_oe_o <= 8'h00;
			port1_out_o <= RST_PORT_DATA;
			port1_oe_o <= 8'h00;
			port2_out_o <= RST_PORT_DATA;
			port2_oe_o <= 8'h00;
			low_addr_data_pins_out_o <= 8'h00;
			low_addr_data_pins_oe_o <= 8'h00;
			high_addr_data_pins_out_o <= 8'h00;
			high_addr_data_pins_oe_o <= 8'h00;
			bus_is_16_o <= 1'b0;
		end else begin
			port0_out_o <= port0_alt_reg ? {1'b0, memory_check_bits_out_i[4], 2'h0,
				memory_check_bits_out_i[3:0]} : 8'h00;
			port0_oe_o <= port0_alt_reg ? ({1'b0, memory_check_bits_oe_i[4], 2'h0,
				memory_check_bits_oe_i[3:0]} & P0_CHECK_MASK) : 8'h00;
			port1_out_o <= p1_out_next;
			port1_oe_o <= p1_oe_next;
			port2_out_o <= p2_out_next;
			port2_oe_o <= p2_oe_next;
			low_addr_data_pins_out_o <= lo_out_next;
			low_addr_data_pins_oe_o <= lo_oe_next;
			high_addr_data_pins_out_o <= hi_out_next;
			high_addr_data_pins_oe_o <= hi_oe_next;
			bus_is_16_o <= bus16;
		end
	end

	// Registers the inputs handed to the peripherals.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			memory_check_bits_in_o <= 5'h00;
			interrupt_seven_o <= 1'b0;
			hold_request_o <= 1'b0;
			serial_rxd_o <= 1'b1;
			timer_b_clock_input_o <= 1'b0;
			baud_clock_input_o <= 1'b0;
			timer_b_reset_input_o <= 1'b0;
			timer_b_direction_input_o <= 1'b0;
			bus_rdata_o <= 16'h0000;
		end else begin
			memory_check_bits_in_o <= {port0_in_i[6], port0_in_i[3:0]};
			interrupt_seven_o <= ext_src;
			hold_request_o <= port1_alt_reg[7] & port1_in_i[7];
			serial_rxd_o <= port2_in_i[1];
			timer_b_clock_input_o <= port2_in_i[3];
			baud_clock_input_o <= port2_in_i[3];
			timer_b_reset_input_o <= port2_in_i[4];
			timer_b_direction_input_o <= port2_in_i[6]; // High counts down.
			bus_rdata_o <= {high_addr_data_pins_in_i, low_addr_data_pins_in_i};
		end
	end

	// Fast pins: dedicated outputs, shared pins and the input path.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			fast_out_dedicated_o <= 4'h0;
			fast_shared_out_o <= 2'h0;
			fast_shared_oe_o <= 2'h0;
			fast_input_pins_o <= 4'h0;
			timer_b_alt_clock_o <= 1'b0;
			timer_b_alt_reset_o <= 1'b0;
		end else begin
			fast_out_dedicated_o <= fast_output_pins_i[3:0];
			fast_shared_out_o <= fast_output_pins_i[5:4];
			fast_shared_oe_o <= fast_share_reg;
			fast_input_pins_o <= {fast_shared_in_i, fast_in_dedicated_i};
			timer_b_alt_clock_o <= fast_in_dedicated_i[0];
			timer_b_alt_reset_o <= fast_in_dedicated_i[1];
		end
	end

	// AHB-Lite address phase; read data is prepared for the data phase.
	assign addr_phase = hsel_i & htrans_i[1] & hready_i;
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (haddr_i[7:0])
			OFS_IO_CONTROL_ONE: rdata_next[7:0] = io_control_one_reg;
			OFS_IO_CONTROL_THREE: rdata_next[7:0] = io_control_three_reg;
			OFS_PORT1_DATA: rdata_next[7:0] = port1_data_reg;
			OFS_PORT2_DATA: rdata_next[7:0] = port2_data_reg;
			OFS_PORT0_ALT: rdata_next[0] = port0_alt_reg;
			OFS_PORT1_ALT: rdata_next[7:0] = port1_alt_reg;
			OFS_PORT2_ALT: rdata_next[7:0] = port2_alt_reg;
			OFS_CHIP_CONFIG: rdata_next[7:0] = chip_config_byte_reg;
			OFS_FAST_SHARE: rdata_next[1:0] = fast_share_reg;
			OFS_IRQ_STATUS: rdata_next[1:0] = status_reg;
			OFS_IRQ_MASK: rdata_next[1:0] = mask_reg;
			OFS_PIN_LEVELS: rdata_next[23:0] = {port2_in_i, port1_in_i, port0_in_i};
			OFS_CAPTURE: rdata_next[15:0] = cap.capture_value;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Bus handshake: ready in every cycle after reset, always OKAY.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			hreadyout_o <= 1'b0;
			hresp_o <= 1'b0;
			hrdata_o <= 32'h0000_0000;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			wr_pend_reg <= addr_phase & hwrite_i;
			if (addr_phase) begin
				wr_addr_reg <= haddr_i[7:0];
				hrdata_o <= hwrite_i ? 32'h0000_0000 : rdata_next;
			end
		end
	end

	// Control register writes in the data phase.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			io_control_one_reg <= RST_CTRL;
			io_control_three_reg <= RST_CTRL;
			port1_data_reg <= RST_PORT_DATA;
			port2_data_reg <= RST_PORT_DATA;
			port0_alt_reg <= 1'b0;
			port1_alt_reg <= RST_CTRL;
			port2_alt_reg <= RST_CTRL;
			chip_config_byte_reg <= RST_CHIP_CONFIG;
			fast_share_reg <= 2'h0;
			mask_reg <= 2'h0;
		end else if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				OFS_IO_CONTROL_ONE: io_control_one_reg <= hwdata_i[7:0];
				OFS_IO_CONTROL_THREE: io_control_three_reg <= hwdata_i[7:0];
				OFS_PORT1_DATA: port1_data_reg <= hwdata_i[7:0];
				OFS_PORT2_DATA: port2_data_reg <= hwdata_i[7:0];
				OFS_PORT0_ALT: port0_alt_reg <= hwdata_i[0];
				OFS_PORT1_ALT: port1_alt_reg <= hwdata_i[7:0] & P1_ALT_MASK;
				OFS_PORT2_ALT: port2_alt_reg <= hwdata_i[7:0];
				OFS_CHIP_CONFIG: chip_config_byte_reg <= hwdata_i[7:0];
				OFS_FAST_SHARE: fast_share_reg <= hwdata_i[1:0];
				OFS_IRQ_MASK: mask_reg <= hwdata_i[1:0];
				default: mask_reg <= mask_reg;
			endcase
		end
	end

	// Sticky event flags; a new event wins over a same-cycle clear.
	assign status_set[ST_INT7_BIT] = ext_src & ~ext_prev_reg;
	assign status_set[ST_CAP_BIT] = cap.capture_pulse;
	assign status_clr = (wr_pend_reg && wr_addr_reg == OFS_IRQ_STATUS) ? hwdata_i[1:0] : 2'h0;
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			status_reg <= 2'h0;
			ext_prev_reg <= 1'b1; // A pin resting on its pull-up gives no false edge.
			irq_o <= 1'b0;
			timer_b_capture_interrupt_o <= 1'b0;
		end else begin
			status_reg <= (status_reg & ~status_clr) | status_set;
			ext_prev_reg <= ext_src;
			irq_o <= |(status_reg & mask_reg);
			timer_b_capture_interrupt_o <= cap.capture_pulse;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_cap_edge;
		!port2_in_i[7] ##1 port2_in_i[7];
	endsequence

	a_port0_input_only: assert property (!port0_alt_reg |=> port0_oe_o == 8'h00)
		else $error("Port zero drives while in default mode.");
	a_check_bits_pins: assert property (port0_alt_reg |=>
		(port0_oe_o & ~P0_CHECK_MASK) == 8'h00 && port0_oe_o[6] == $past(memory_check_bits_oe_i[4]))
		else $error("Check bits on wrong port-zero pins.");
	a_pulse_width_out_one_route: assert property (io_control_three_reg[IO_CONTROL_THREE_PULSE_WIDTH_OUT_ONE_BIT] |=> port1_oe_o[3]
		&& port1_out_o[3] == $past(pulse_width_out_one_i))
		else $error("Pulse one not on port-one pin 3.");
	a_pulse_width_out_two_route: assert property (io_control_three_reg[IO_CONTROL_THREE_PULSE_WIDTH_OUT_TWO_BIT] |=> port1_oe_o[4]
		&& port1_out_o[4] == $past(pulse_width_out_two_i))
		else $error("Pulse two not on port-one pin 4.");
	a_quasi_drive: assert property (!io_control_three_reg[IO_CONTROL_THREE_PULSE_WIDTH_OUT_ONE_BIT] |=>
		port1_oe_o[3] == !$past(port1_data_reg[3]) && port1_out_o[3] == $past(port1_data_reg[3]))
		else $error("Unselected pin does not follow port data.");
	a_ext_source: assert property (##1 interrupt_seven_o == $past(io_control_one_reg[1] ?
		port0_in_i[7] : port2_in_i[2]))
		else $error("External interrupt from wrong pin.");
	a_bus_request: assert property (port1_alt_reg[5] |=> port1_oe_o[5]
		&& port1_out_o[5] == $past(cycle_pending_i))
		else $error("Bus request pin does not follow the pending cycle.");
	a_hold_ack: assert property (port1_alt_reg[6] |=> port1_oe_o[6]
		&& port1_out_o[6] == $past(bus_released_i))
		else $error("Hold acknowledge pin wrong.");
	a_low_addr_phase: assert property (bus_phase_i == PH_ADDR |=>
		low_addr_data_pins_oe_o == 8'hFF && low_addr_data_pins_out_o == $past(bus_addr_i[7:0]))
		else $error("Low pins do not drive the address.");
	a_narrow_upper: assert property (!bus16 |=>
		high_addr_data_pins_oe_o == 8'hFF && high_addr_data_pins_out_o == $past(bus_addr_i[15:8]))
		else $error("Upper pins not dedicated address in narrow mode.");
	a_width_lock: assert property (!chip_config_byte_reg[CCB_DYN_WIDTH_BIT]
		|=> !bus_is_16_o)
		else $error("Bus not locked narrow.");
	a_capture_irq: assert property (s_cap_edge |-> ##2 status_reg[ST_CAP_BIT]
		&& timer_b_capture_interrupt_o)
		else $error("Capture edge did not raise its interrupt.");

endmodule // port_alternate_function_mux
`default_nettype wire

// [tb/pin_board.sv]
// Purpose: Board model around the pins: pull-ups, external drivers and a bus-hold master.
// Assumes: One clock; the bench chooses what the board drives on each wire.
// Notes: A wire nobody drives rests high on its pull-up.
`timescale 1ns/10ps
`default_nettype none
module pin_board #(
	parameter int W = 8
) (
	// Device side of the wires.
	input wire logic [W-1:0] dev_out_i,
	input wire logic [W-1:0] dev_oe_i,
	// Board side of the wires.
	input wire logic [W-1:0] ext_en_i,
	input wire logic [W-1:0] ext_val_i,
	output logic [W-1:0] pin_o
);
	// Resolve each wire: device drive, else board drive, else the pull-up.
	always_comb begin
		for (int k = 0; k < W; k++) begin
			pin_o[k] = dev_oe_i[k] ? dev_out_i[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
		end
	end
endmodule // pin_board

module hold_master (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Hold handshake.
	input wire logic want_i,
	input wire logic ack_i,
	output logic hold_o,
	output logic owns_bus_o
);
	// Raise the hold request and take the bus only once the acknowledge is seen.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			hold_o <= 1'b0;
			owns_bus_o <= 1'b0;
		end else begin
			hold_o <= want_i;
			owns_bus_o <= want_i & hold_o & ack_i;
		end
	end
endmodule // hold_master
`default_nettype wire

// [tb/port_alternate_function_mux_tb.sv]
// Purpose: Self-checking bench for the port alternate-function multiplexer.
// Assumes: Zero-wait AHB-Lite slave; pins resolved by the board model.
// Notes: Pin outputs lag their cause by one cycle, so checks wait three edges.
`timescale 1ns/10ps
`default_nettype none
module port_alternate_function_mux_tb import pinmux_pkg::*;;
	// Design ports; driven inputs start at known values.
	logic clk_sys_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, hready_i;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic hreadyout_o, hresp_o, irq_o;
	logic [7:0] port0_in_i, port0_out_o, port0_oe_o, port1_in_i, port1_out_o, port1_oe_o;
	logic [7:0] port2_in_i, port2_out_o, port2_oe_o;
	logic [4:0] memory_check_bits_out_i = 5'h15, memory_check_bits_oe_i = 5'h1F;
	logic [4:0] memory_check_bits_in_o;
	logic pulse_width_out_zero_i = 1'b1, pulse_width_out_one_i = 1'b1, pulse_width_out_two_i = 1'b0;
	logic serial_txd_i = 1'b0, cycle_pending_i = 1'b0, bus_released_i = 1'b0;
	logic [15:0] timer_b_value_i = 16'hA5C3, bus_addr_i = 16'h2B7E, bus_wdata_i = 16'h9D41;
	logic [15:0] bus_rdata_o;
	logic interrupt_seven_o, timer_b_capture_interrupt_o, hold_request_o, serial_rxd_o;
	logic timer_b_clock_input_o, baud_clock_input_o, timer_b_reset_input_o;
	logic timer_b_direction_input_o, timer_b_alt_clock_o, timer_b_alt_reset_o;
	bus_phase_t bus_phase_i = PH_IDLE;
	logic bus_write_i = 1'b0, width_select_pin_i = 1'b1, bus_is_16_o;
	logic [7:0] low_addr_data_pins_in_i, high_addr_data_pins_in_i, low_addr_data_pins_out_o;
	logic [7:0] low_addr_data_pins_oe_o, high_addr_data_pins_out_o, high_addr_data_pins_oe_o;
	logic [5:0] fast_output_pins_i = 6'h2D;
	logic [1:0] fast_in_dedicated_i = 2'h2, fast_shared_in_i = 2'h1;
	logic [1:0] fast_shared_out_o, fast_shared_oe_o;
	logic [3:0] fast_out_dedicated_o, fast_input_pins_o;
	// Board drive per net: ports 0 to 2, then low and high address/data.
	logic [7:0] ext_en [0:4] = '{8'h00, 8'h80, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0] ext_val [0:4] = '{8'h0A, 8'h00, 8'h00, 8'h5A, 8'hC3};
	logic hold_want = 1'b0, hold_line, owns_bus;
	int fails = 0, n_compared = 0;

	// Device, board wires and hold master.
	assign hready_i = hreadyout_o;
	port_alternate_function_mux port_alternate_function_mux_i (.*);
	pin_board pin_board_p0_i (.dev_out_i(port0_out_o), .dev_oe_i(port0_oe_o),
		.ext_en_i(ext_en[0]), .ext_val_i(ext_val[0]), .pin_o(port0_in_i));
	pin_board pin_board_p1_i (.dev_out_i(port1_out_o), .dev_oe_i(port1_oe_o),
		.ext_en_i(ext_en[1]), .ext_val_i({hold_line, ext_val[1][6:0]}), .pin_o(port1_in_i));
	pin_board pin_board_p2_i (.dev_out_i(port2_out_o), .dev_oe_i(port2_oe_o),
		.ext_en_i(ext_en[2]), .ext_val_i(ext_val[2]), .pin_o(port2_in_i));
	pin_board pin_board_lo_i (.dev_out_i(low_addr_data_pins_out_o), .dev_oe_i(low_addr_data_pins_oe_o),
		.ext_en_i(ext_en[3]), .ext_val_i(ext_val[3]), .pin_o(low_addr_data_pins_in_i));
	pin_board pin_board_hi_i (.dev_out_i(high_addr_data_pins_out_o), .dev_oe_i(high_addr_data_pins_oe_o),
		.ext_en_i(ext_en[4]), .ext_val_i(ext_val[4]), .pin_o(high_addr_data_pins_in_i));
	hold_master hold_master_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .want_i(hold_want),
		.ack_i(port1_in_i[6]), .hold_o(hold_line), .owns_bus_o(owns_bus));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// Compare one value and count it.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Let a number of clock edges pass.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// Wait for hready at a rising edge, with a bound.
	task automatic wait_ready();
		for (int k = 0; k <= 50; k++) begin
			@(posedge clk_sys_i);
			if (hreadyout_o === 1'b1) return;
		end
		fails++;
		tally_and_finish();
	endtask

	// One single AHB-Lite word transfer.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel_i <= 1'b1;
		haddr_i <= {24'h000000, a};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		wait_ready();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_ready();
		q = hrdata_o;
		chk("hresp", 32'h0, hresp_o);
	endtask

	// Register write, and register read with comparison.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask

	// Set a bus phase and check both address/data bytes, data masked by enables.
	task automatic adchk(input bus_phase_t ph, input logic w, input logic [31:0] exp);
		bus_phase_i <= ph;
		bus_write_i <= w;
		tick(3);
		chk("ad_pins", exp, {low_addr_data_pins_oe_o, low_addr_data_pins_out_o &
			low_addr_data_pins_oe_o, high_addr_data_pins_oe_o,
			high_addr_data_pins_out_o & high_addr_data_pins_oe_o});
	endtask

	// Print the counts and the verdict, then stop.
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Reset, then one group of calls per pin function.
	initial begin
		int cnt;
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		tick(2);
		chk("p0_oe", 8'h00, port0_oe_o);
		rdchk("p1_data", OFS_PORT1_DATA, 32'hFF);
		rdchk("unmapped", 8'h40, 32'h0);
		wr(OFS_PORT1_DATA, 32'hF5);
		tick(3);
		chk("p1_quasi", 8'hA5, {port1_oe_o[3:0], port1_out_o[3:0]});
		wr(OFS_IO_CONTROL_THREE, 32'hC);
		tick(3);
		chk("p1_pwm", 4'hD, {port1_oe_o[4:3], port1_out_o[4:3]});
		pulse_width_out_one_i <= 1'b0;
		pulse_width_out_two_i <= 1'b1;
		tick(3);
		chk("p1_pwm", 4'hE, {port1_oe_o[4:3], port1_out_o[4:3]});
		wr(OFS_PORT1_ALT, 32'hE0);
		cycle_pending_i <= 1'b1;
		hold_want <= 1'b1;
		tick(4);
		chk("p1_hold", 8'h35, {2'b00, port1_oe_o[6:5], port1_out_o[6:5], owns_bus,
			hold_request_o});
		bus_released_i <= 1'b1;
		tick(4);
		chk("p1_hold", 8'h3F, {2'b00, port1_oe_o[6:5], port1_out_o[6:5], owns_bus,
			hold_request_o});
		wr(OFS_PORT0_ALT, 32'h1);
		tick(3);
		chk("p0_check", 16'h4F45, {port0_oe_o, port0_out_o & 8'h4F});
		memory_check_bits_oe_i <= 5'h00;
		ext_en[0] <= 8'hFF;
		tick(3);
		chk("p0_check_in", 16'h000A, {port0_oe_o, 3'h0, memory_check_bits_in_o});
		wr(OFS_IRQ_MASK, 32'h3);
		wr(OFS_IO_CONTROL_ONE, 32'h2);
		ext_val[0] <= 8'h8A;
		tick(4);
		chk("int_p0", 2'h3, {interrupt_seven_o, irq_o});
		rdchk("status", OFS_IRQ_STATUS, 32'h1);
		wr(OFS_IO_CONTROL_ONE, 32'h0);
		wr(OFS_IRQ_STATUS, 32'h3);
		wr(OFS_IRQ_MASK, 32'h0);
		tick(2);
		chk("irq_clear", 1'b0, irq_o);
		rdchk("status", OFS_IRQ_STATUS, 32'h0);
		ext_val[2] <= 8'h04;
		tick(4);
		chk("int_p2", 2'h2, {interrupt_seven_o, irq_o});
		rdchk("status", OFS_IRQ_STATUS, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		tick(3);
		chk("irq_unmask", 1'b1, irq_o);
		wr(OFS_PORT2_ALT, 32'h21);
		tick(3);
		chk("p2_alt", 4'hE, {port2_oe_o[5], port2_oe_o[0], port2_out_o[5], port2_out_o[0]});
		for (int v = 0; v < 2; v++) begin
			ext_val[2] <= {1'b0, v[0], 1'b0, ~v[0], v[0], 1'b0, ~v[0], 1'b0};
			tick(3);
			chk("p2_in", {v[0], v[0], ~v[0], v[0], ~v[0]}, {timer_b_clock_input_o,
				baud_clock_input_o, timer_b_reset_input_o, timer_b_direction_input_o,
				serial_rxd_o});
		end
		wr(OFS_IRQ_STATUS, 32'h3);
		cnt = 0;
		ext_val[2][7] <= 1'b1;
		repeat (6) begin
			@(posedge clk_sys_i);
			cnt += (timer_b_capture_interrupt_o === 1'b1);
		end
		timer_b_value_i <= 16'h1234;
		chk("cap_pulse", 32'h1, cnt);
		rdchk("capture", OFS_CAPTURE, 32'hA5C3);
		rdchk("status", OFS_IRQ_STATUS, 32'h2);
		adchk(PH_ADDR, 1'b1, 32'hFF7EFF2B);
		adchk(PH_DATA, 1'b1, 32'hFF41FF2B);
		adchk(PH_IDLE, 1'b0, 32'h0000FF2B);
		chk("bus16", 1'b0, bus_is_16_o);
		wr(OFS_CHIP_CONFIG, 32'h2);
		adchk(PH_DATA, 1'b1, 32'hFF41FF9D);
		adchk(PH_DATA, 1'b0, 32'h00000000);
		chk("bus_rd", 17'h1C35A, {bus_is_16_o, bus_rdata_o});
		width_select_pin_i <= 1'b0;
		adchk(PH_DATA, 1'b0, 32'h0000FF2B);
		chk("fast", 8'h0D, {fast_shared_oe_o, fast_shared_out_o & fast_shared_oe_o,
			fast_out_dedicated_o});
		wr(OFS_FAST_SHARE, 32'h3);
		tick(3);
		chk("fast", 8'hED, {fast_shared_oe_o, fast_shared_out_o, fast_out_dedicated_o});
		chk("fast_in", 6'h1A, {fast_input_pins_o, timer_b_alt_reset_o, timer_b_alt_clock_o});
		tally_and_finish();
	end
endmodule // port_alternate_function_mux_tb
`default_nettype wire
